// ### common/vdf_pkg.sv
// Purpose: Constants for the video display file fetch block
// Assumes: 16-bit RAM address space, 8-bit data
// Notes:   Offsets and fields for the design; the bench uses its own literals
package vdf_pkg;

  // Display file layout
  localparam logic [15:0] VDF_PRIMARY_BASE = 16'h4000;
  localparam logic [15:0] VDF_SECOND_BASE  = 16'h6000;
  localparam logic [15:0] VDF_FILE_SIZE    = 16'h1800;
  localparam logic [15:0] VDF_ATTR_BASE    = 16'h5800;
  localparam logic [15:0] VDF_ATTR_COUNT   = 16'h0300;
  localparam logic [15:0] VDF_BLOCK_STEP   = 16'h0800;
  localparam logic [15:0] VDF_LINE_STEP    = 16'h0020;
  localparam logic [15:0] VDF_ROW_STEP     = 16'h0100;
  localparam int          VDF_FILE_SEL_BIT = 13;
  localparam logic [7:0]  VDF_ATTR_HI      = 8'h58;
  localparam int          VDF_LINES_PER_BLK = 8;
  localparam int          VDF_ROWS_PER_CELL = 8;

  // Mode port
  localparam logic [7:0]  VDF_MODE_PORT    = 8'hff;
  localparam logic [7:0]  VDF_MODE_RESET   = 8'h00;
  localparam logic [5:0]  VDF_MODE_DUAL    = 6'h01;
  localparam logic [5:0]  VDF_MODE_HICOLOR = 6'h02;
  localparam logic [2:0]  VDF_MODE_COL64   = 3'h6;
  localparam int          VDF_MODE_LSB     = 0;
  localparam int          VDF_INK_LSB      = 3;

  // Screen geometry
  localparam logic [4:0]  VDF_LAST_LINE    = 5'h17;
  localparam logic [5:0]  VDF_LAST_COL64   = 6'h3f;
  localparam logic [4:0]  VDF_LAST_COL32   = 5'h1f;
  localparam logic [2:0]  VDF_LAST_ROW     = 3'h7;

  typedef enum logic [1:0] {
    VDF_NORMAL,
    VDF_DUAL,
    VDF_HICOLOR,
    VDF_COL64
  } vdf_mode_t;

endpackage

// ### rtl/vdf_fetch.sv
// Purpose: Walks the screen and fetches pixel and colour bytes from RAM
// Assumes: RAM answers a read in the cycle after o_mem_rd, with i_mem_data
// Notes:   Output words pass a two-entry buffer; the sink may stall
//          A mode write takes effect for the next read issued, so the cell
//          in flight when the mode changes may show parts of both modes
//
// Function
// - Fetch from primary file at 4000H and second file at 6000H, 1800H each.
// - Mode is low six bits of byte written to I/O video_mode_control.
// - Pixel area is three blocks of eight character lines each.
// - Matching locations in both files differ only in address bit 13.
// - Eight pixel bytes per cell, rows 100H apart.
// - Normal mode colour from 768 attribute bytes at 5800H, row-major.
// - Line start is base plus block times 800H plus line times 20H.
// - Attribute high byte is 58H OR block bits; low byte as pixel.
// - 64-column mode: odd columns from second file, offset column/2.
// - 64-column mode colour comes from mode setting, not RAM.
// - Mode value 1 displays the second file.
// - Dual screen: second file uses same layout as primary.
// - Writing zero to port 255 returns to normal primary screen.
// - Mode value 2 selects per-byte colour from second file.
// - High-colour attribute address is pixel address with bit 13 set.
// - Mode bits 0-2 equal 6 select 64 columns; bits 3-5 pick colours.
// - 64-column mode forces bright and flash off; border follows paper.
`timescale 1ns/1ps

module vdf_fetch
  import vdf_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Host I/O write strobe
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_io_addr,
  input  wire logic [7:0]  i_io_data,
  // Display RAM read port
  output logic             o_mem_rd,
  output logic [15:0]      o_mem_addr,
  input  wire logic [7:0]  i_mem_data,
  // Fetched cell stream
  output logic             o_pix_valid,
  input  wire logic        i_pix_ready,
  output logic [7:0]       o_pix_data,
  output logic [7:0]       o_pix_attr,
  output logic             o_pix_frame_start,
  // Mode and border status
  output logic [5:0]       o_mode,
  output logic [2:0]       o_border,
  output logic             o_border_force
);

  // Fetch sequence for one cell row, five cycles in colour modes:
  //   PIX   issue pixel read (only when the output buffer has room)
  //   PIXW  RAM works on the pixel read
  //   ATTR  take pixel byte; issue colour read, or push in 64 columns
  //   ATTRW RAM works on the colour read
  //   ATTRD take colour byte and push the finished word
  // RAM data stands for one cycle only, so each byte is taken exactly
  // two edges after its read strobe and never a cycle earlier.
  typedef enum logic [2:0] {
    VDF_S_PIX,
    VDF_S_PIXW,
    VDF_S_ATTR,
    VDF_S_ATTRW,
    VDF_S_ATTRD
  } vdf_state_t;

  // Whole state of the block in one word
  typedef struct packed {
    logic [7:0]  mode;
    vdf_state_t  st;
    logic [4:0]  line;
    logic [2:0]  row;
    logic [5:0]  col;
    logic [7:0]  pix;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic [1:0]  cnt;
    logic [1:0]  wp;
    logic [1:0]  rp;
    logic [7:0]  b_pix0;
    logic [7:0]  b_pix1;
    logic [7:0]  b_attr0;
    logic [7:0]  b_attr1;
    logic        b_sof0;
    logic        b_sof1;
    logic        out_v;
    logic [7:0]  out_pix;
    logic [7:0]  out_attr;
    logic        out_sof;
    logic [2:0]  border;
    logic        border_force;
  } vdf_regs_t;

  vdf_regs_t s_r;
  vdf_regs_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address helpers
  // Both files share one layout; bit 13 alone picks the file

  // Mode decode from low six bits
  // 64-column test looks at bits 0-2 only; bits 3-5 then carry the ink
  function automatic vdf_mode_t mode_of(input logic [7:0] m);
    if (m[2:0] == VDF_MODE_COL64) begin
      mode_of = VDF_COL64;
    end else if (m[5:0] == VDF_MODE_DUAL) begin
      mode_of = VDF_DUAL;
    end else if (m[5:0] == VDF_MODE_HICOLOR) begin
      mode_of = VDF_HICOLOR;
    end else begin
      mode_of = VDF_NORMAL;
    end
  endfunction

  // Pixel address of a cell row within a file
  function automatic logic [15:0] pix_addr(input logic       second,
                                           input logic [4:0] line,
                                           input logic [2:0] row,
                                           input logic [4:0] col);
    logic [15:0] a;
    a = VDF_PRIMARY_BASE
        + 16'(line[4:3]) * VDF_BLOCK_STEP
        + 16'(line[2:0]) * VDF_LINE_STEP
        + 16'(row) * VDF_ROW_STEP
        + 16'(col);
    a[VDF_FILE_SEL_BIT] = second;
    pix_addr = a;
  endfunction

  // Attribute address for a cell in normal layout
  // Dual screen keeps the same colour layout inside the second file
  function automatic logic [15:0] attr_addr(input logic [15:0] p, input logic second);
    logic [15:0] a;
    a = {VDF_ATTR_HI | {6'h00, p[12:11]}, p[7:0]};
    a[VDF_FILE_SEL_BIT] = second;
    attr_addr = a;
  endfunction

  // Fixed colour pair in 64-column mode
  function automatic logic [7:0] col64_attr(input logic [2:0] ink);
    col64_attr = {2'b00, ~ink, ink};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    vdf_mode_t   md;
    logic        second;
    logic [4:0]  fcol;
    logic [15:0] pa;
    logic        push;
    logic        pop;
    logic        last_col;
    logic        sof;
    md       = mode_of(s_r.mode);
    second   = 1'b0;
    fcol     = s_r.col[4:0];
    pa       = 16'h0000;
    push     = 1'b0;
    pop      = 1'b0;
    last_col = 1'b0;
    sof      = 1'b0;
    s_nxt    = s_r;

    // Mode port write; zero restores normal primary screen
    if (i_io_wr && i_io_addr == VDF_MODE_PORT) begin
      s_nxt.mode = i_io_data;
    end

    // Border follows the paper colour; registered with the mode itself
    s_nxt.border       = ~s_nxt.mode[5:3];
    s_nxt.border_force = (s_nxt.mode[2:0] == VDF_MODE_COL64);

    // File and column selection per mode
    // 64 columns alternate files; dual screen shows the second file whole
    if (md == VDF_COL64) begin
      second = s_r.col[0];
      fcol   = s_r.col[5:1];
    end else if (md == VDF_DUAL) begin
      second = 1'b1;
    end
    // Cell row address, then end-of-line and frame-start tests
    pa       = pix_addr(second, s_r.line, s_r.row, fcol);
    last_col = (md == VDF_COL64) ? (s_r.col == VDF_LAST_COL64)
                                 : (s_r.col[4:0] == VDF_LAST_COL32);
    sof      = (s_r.line == 5'h00) && (s_r.row == 3'h0) && (s_r.col == 6'h00);

    // Read strobe is a one-cycle pulse; the address stands until the next
    s_nxt.mem_rd = 1'b0;
    case (s_r.st)
      VDF_S_PIX: begin
        // Wait for buffer room before fetching a cell
        if (s_r.cnt != 2'd2) begin
          s_nxt.mem_rd   = 1'b1;
          s_nxt.mem_addr = pa;
          s_nxt.st       = VDF_S_PIXW;
        end
      end
      VDF_S_PIXW: begin
        s_nxt.st = VDF_S_ATTR;
      end
      VDF_S_ATTR: begin
        s_nxt.pix = i_mem_data;
        if (md == VDF_COL64) begin
          push = 1'b1;
        end else begin
          s_nxt.mem_rd = 1'b1;
          if (md == VDF_HICOLOR) begin
            s_nxt.mem_addr = pa | (16'h0001 << VDF_FILE_SEL_BIT);
          end else begin
            s_nxt.mem_addr = attr_addr(pa, second);
          end
          s_nxt.st = VDF_S_ATTRW;
        end
      end
      VDF_S_ATTRW: begin
        s_nxt.st = VDF_S_ATTRD;
      end
      VDF_S_ATTRD: begin
        // Colour byte is on the bus now; the push below retires the cell
        s_nxt.st = VDF_S_PIX;
      end
      default: begin
        s_nxt.st = VDF_S_PIX;
      end
    endcase

    // Word source follows the pushing state, not the mode, so a mode write
    // between the two reads of a cell cannot mix the byte sources: a push in
    // ATTR takes the pixel off the bus with colour from the mode, a push in
    // ATTRD takes the colour off the bus and the pixel from the register
    if (push || (s_r.st == VDF_S_ATTRD)) begin
      if (s_r.wp[0]) begin
        s_nxt.b_pix1  = push ? i_mem_data : s_r.pix;
        s_nxt.b_attr1 = push ? col64_attr(s_r.mode[5:3]) : i_mem_data;
        s_nxt.b_sof1  = sof;
      end else begin
        s_nxt.b_pix0  = push ? i_mem_data : s_r.pix;
        s_nxt.b_attr0 = push ? col64_attr(s_r.mode[5:3]) : i_mem_data;
        s_nxt.b_sof0  = sof;
      end
      s_nxt.wp = s_r.wp + 2'd1;
      s_nxt.st = VDF_S_PIX;
      // Advance scan position
      if (last_col) begin
        s_nxt.col = 6'h00;
        if (s_r.row == VDF_LAST_ROW) begin
          s_nxt.row  = 3'h0;
          s_nxt.line = (s_r.line == VDF_LAST_LINE) ? 5'h00 : s_r.line + 5'd1;
        end else begin
          s_nxt.row = s_r.row + 3'd1;
        end
      end else begin
        s_nxt.col = s_r.col + 6'd1;
      end
      push = 1'b1;
    end

    // Output register drains buffer under sink back-pressure
    // Fetch only starts a cell while an entry is free, and one cell is in
    // flight at most, so a stall of any length loses no word
    if (!s_r.out_v || i_pix_ready) begin
      s_nxt.out_v = (s_r.cnt != 2'd0);
      if (s_r.cnt != 2'd0) begin
        s_nxt.out_pix  = s_r.rp[0] ? s_r.b_pix1 : s_r.b_pix0;
        s_nxt.out_attr = s_r.rp[0] ? s_r.b_attr1 : s_r.b_attr0;
        s_nxt.out_sof  = s_r.rp[0] ? s_r.b_sof1 : s_r.b_sof0;
        s_nxt.rp       = s_r.rp + 2'd1;
        pop            = 1'b1;
      end
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  // Reset clears the whole word; mode, state and border are named, and only border resets non-zero

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r      <= '0;
      s_r.mode <= VDF_MODE_RESET;
      s_r.st   <= VDF_S_PIX;
      s_r.border <= ~VDF_MODE_RESET[5:3]; // Paper of the reset mode
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops

  assign o_mem_rd          = s_r.mem_rd;
  assign o_mem_addr        = s_r.mem_addr;
  assign o_pix_valid       = s_r.out_v;
  assign o_pix_data        = s_r.out_pix;
  assign o_pix_attr        = s_r.out_attr;
  assign o_pix_frame_start = s_r.out_sof;
  assign o_mode            = s_r.mode[5:0];
  assign o_border          = s_r.border;            // Paper colour
  assign o_border_force    = s_r.border_force;

endmodule

// ### testbench/vdf_fetch_properties.sv
// Purpose: Port assertions for the display fetch block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to every fetch block instance
`timescale 1ns/1ps
module vdf_fetch_chk (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_io_wr,
  input wire logic [7:0]  i_io_addr,
  input wire logic [7:0]  i_io_data,
  input wire logic        o_mem_rd,
  input wire logic [15:0] o_mem_addr,
  input wire logic [7:0]  i_mem_data,
  input wire logic        o_pix_valid,
  input wire logic        i_pix_ready,
  input wire logic [7:0]  o_pix_data,
  input wire logic [7:0]  o_pix_attr,
  input wire logic        o_pix_frame_start,
  input wire logic [5:0]  o_mode,
  input wire logic [2:0]  o_border,
  input wire logic        o_border_force
);
  // Last read address and 64-column flag
  logic [15:0] pix_addr_r;
  wire logic   c64_w = (o_mode[2:0] == 3'h6);
  always_ff @(posedge i_clk) begin
    if (o_mem_rd) begin
      pix_addr_r <= o_mem_addr;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  mode_take_a: assert property (
    i_io_wr && i_io_addr == 8'hff |=> {2'b00, o_mode} == ($past(i_io_data) & 8'h3f))
    else $error("mode write not taken");
  mode_hold_a: assert property (
    !(i_io_wr && i_io_addr == 8'hff) |=> $stable(o_mode)) else $error("mode changed");
  file_range_a: assert property (
    o_mem_rd |-> o_mem_addr[15:14] == 2'b01 && o_mem_addr[12:0] < 13'h1b00 ##1 !o_mem_rd)
    else $error("read outside display files");
  dual_file_a: assert property (
    o_mem_rd && o_mode == 6'h01 && $past(o_mode) == 6'h01 && $past(o_mode, 2) == 6'h01
    |-> o_mem_addr[13]) else $error("dual read from primary file");
  attr_pair_a: assert property (
    o_mem_rd && o_mem_addr[13:11] == 3'b011 && o_mode == 6'h00 && $past(o_mode) == 6'h00
    |-> $past(o_mem_rd, 2) && o_mem_addr == {6'b010110, pix_addr_r[12:11], pix_addr_r[7:0]})
    else $error("colour address wrong");
  hicolor_attr_a: assert property (
    o_mem_rd && o_mem_addr[13] && o_mode == 6'h02 && $past(o_mode) == 6'h02
    |-> $past(o_mem_rd, 2) && o_mem_addr == (pix_addr_r | 16'h2000))
    else $error("hi-colour address wrong");
  col64_attr_a: assert property (
    o_mem_rd && c64_w && $past(c64_w) && $past(c64_w, 2) |-> o_mem_addr[12:11] != 2'b11)
    else $error("colour read in 64 columns");
  border_a: assert property (
    $stable(o_mode) |-> o_border_force == c64_w && o_border == ~o_mode[5:3])
    else $error("border wrong");
  stall_hold_a: assert property (
    o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data) && $stable(o_pix_attr))
    else $error("word changed in stall");
endmodule
bind vdf_fetch vdf_fetch_chk vdf_fetch_chk_inst (.*);

// ### testbench/vdf_fetch_tb_top.sv
// Purpose: Self-checking bench for the display fetch block
// Assumes: RAM model byte is address high XOR low
// Notes:   Rows set a mode after reset and check early words
`timescale 1ns/1ps
module vdf_fetch_tb_top;
  typedef struct packed {
    logic [7:0] adr, dat, phe, pho, ahi;
    logic       c64;
  } vdf_row_t;
  logic        i_clk, i_sys_rst, i_io_wr, i_pix_ready, f;
  logic        o_mem_rd, o_pix_valid, o_pix_frame_start, o_border_force;
  logic [7:0]  i_io_addr, i_io_data, i_mem_data, o_pix_data, o_pix_attr, d, a, e;
  logic [15:0] o_mem_addr;
  logic [5:0]  o_mode;
  logic [2:0]  o_border;
  int          mismatches = 0, samples_checked = 0, cyc = 0, n;
  // Port, data, pixel high even and odd, colour, 64-column
  vdf_row_t    rows [7] = '{
    '{8'hff, 8'h00, 8'h40, 8'h40, 8'h58, 1'b0}, '{8'hff, 8'h01, 8'h60, 8'h60, 8'h78, 1'b0},
    '{8'hff, 8'h02, 8'h40, 8'h40, 8'h60, 1'b0}, '{8'hff, 8'h06, 8'h40, 8'h60, 8'h38, 1'b1},
    '{8'hfe, 8'h01, 8'h40, 8'h40, 8'h58, 1'b0}, '{8'hff, 8'hc1, 8'h60, 8'h60, 8'h78, 1'b0},
    '{8'hff, 8'h36, 8'h40, 8'h60, 8'h0e, 1'b1}};
  vdf_fetch vdf_fetch_inst (.*);
  vdf_ram_model vdf_ram_model_inst (.i_clk(i_clk), .i_rd(o_mem_rd), .i_addr(o_mem_addr),
                                    .o_data(i_mem_data));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // Cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [7:0] ex, got);
    samples_checked++;
    if (ex !== got) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, dt);
    i_io_wr   <= 1'b1;
    i_io_addr <= ad;
    i_io_data <= dt;
    @(posedge i_clk);
  endtask
  task automatic rst();
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
  endtask
  task automatic take();
    @(posedge i_clk);
    while (!(o_pix_valid === 1'b1 && i_pix_ready === 1'b1)) @(posedge i_clk);
    d = o_pix_data;
    a = o_pix_attr;
    f = o_pix_frame_start;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_sys_rst   = 1'b1;
    i_io_wr     = 1'b0;
    i_io_addr   = 8'h00;
    i_io_data   = 8'h00;
    i_pix_ready = 1'b0;
    repeat (12) @(posedge i_clk);
    chk("reset mode", 8'h00, 8'(o_mode));
    chk("reset border", 8'h07, 8'(o_border));
    chk("reset valid", 8'h00, 8'(o_pix_valid));
    i_sys_rst   <= 1'b0;
    i_pix_ready <= 1'b1;
    // Whole normal frame with stalls; every word checked
    for (n = 0; n < 6144; n++) begin
      take();
      chk("pixel", {3'b010, n[12:11], n[7:5]} ^ {n[10:8], n[4:0]}, d);
      chk("colour", {6'b010110, n[12:11]} ^ {n[10:8], n[4:0]}, a);
      chk("frame start", 8'(n == 0), 8'(f));
      if (n % 97 == 5) begin
        i_pix_ready <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_pix_ready <= 1'b1;
      end
    end
    take();
    chk("wrap", 8'h01, 8'(f));
    // One mode per row, set right after a reset
    foreach (rows[k]) begin
      rst();
      chk("reset again", 8'h00, 8'(o_mode));
      wr(rows[k].adr, rows[k].dat);
      i_io_wr <= 1'b0;
      for (n = 0; n < 8; n++) begin
        take();
        e = rows[k].c64 ? 8'(n / 2) : 8'(n);
        if (n > 3) begin
          chk("row pixel", (n % 2 == 1 ? rows[k].pho : rows[k].phe) ^ e, d);
          chk("row colour", rows[k].c64 ? rows[k].ahi : rows[k].ahi ^ e, a);
        end
      end
      chk("mode", rows[k].adr == 8'hff ? rows[k].dat & 8'h3f : 8'h00, 8'(o_mode));
    end
    // Back-to-back writes; zero restores the standard screen
    wr(8'hff, 8'h02);
    wr(8'hff, 8'h00);
    i_io_wr <= 1'b0;
    @(posedge i_clk);
    chk("zero write", 8'h00, 8'(o_mode));
    close_out();
  end
endmodule

// ### testbench/vdf_ram_model.sv
// Purpose: Display RAM seen by the fetch block
// Assumes: Read answered on the edge after the request
// Notes:   Byte is address high XOR low, so words show their source
`timescale 1ns/1ps
module vdf_ram_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output logic      [7:0]  o_data
);
  // Answer a read, then scramble once the hold has run out
  always_ff @(posedge i_clk) begin
    if (i_rd) begin
      o_data <= i_addr[15:8] ^ i_addr[7:0];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule
